// >>> hw/ftt_chan.sv
// one temperature channel: offset, start and critical hysteresis
`timescale 1ns/1ps
`default_nettype none
module ftt_chan (
   input  wire logic                      clk_i,
   input  wire logic                      rst_b_i,
   input  wire logic                      ce_i,
   input  wire logic [ftt_pkg::TEMP_W-1:0] temp_i,
   input  var  ftt_pkg::ftt_chan_cfg_t    cfg_i,
   output var  ftt_pkg::ftt_chan_st_t     st_o
);
   typedef struct packed {
      logic above;
      logic fan_on;
      logic run;
      logic crit;
   } ftt_cs_t;

   ftt_cs_t    cs_reg;
   ftt_cs_t    cs_next;
   logic [11:0] sum;
   logic [9:0]  corr;
   logic [7:0]  deg;
   logic        crit_en;
   logic        off_pt;
   logic        crit_clr;

   always_comb begin
      sum = {2'h0, temp_i} + {{4{cfg_i.ofs[7]}}, cfg_i.ofs};
      if (sum[11]) begin
         corr = 10'h000;
      end else if (sum[10]) begin
         corr = 10'h3ff;
      end else begin
         corr = sum[9:0];
      end
      deg      = corr[9:ftt_pkg::FRAC_W];
      crit_en  = cfg_i.crit != ftt_pkg::CRIT_OFF;
      off_pt   = ({1'b0, deg} + {5'h00, cfg_i.hyst}) <= {1'b0, cfg_i.start};
      crit_clr = !crit_en ||
                 (({1'b0, deg} + {5'h00, cfg_i.hyst}) < {1'b0, cfg_i.crit});
      cs_next = cs_reg;
      if (ce_i) begin
         cs_next.above = deg > cfg_i.start;
         if (cs_next.above) begin
            cs_next.fan_on = 1'b1;
         end else if (off_pt) begin
            cs_next.fan_on = 1'b0;
         end
         cs_next.run = cs_next.fan_on | cfg_i.hold;
         if (crit_en && deg > cfg_i.crit) begin
            cs_next.crit = 1'b1;
         end else if (crit_clr) begin
            cs_next.crit = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cs_reg <= '0;
      end else begin
         cs_reg <= cs_next;
      end
   end

   always_comb begin
      st_o.above = cs_reg.above;
      st_o.run   = cs_reg.run;
      st_o.crit  = cs_reg.crit;
      st_o.trip  = crit_en && (corr > {cfg_i.crit, 2'h0});
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_start;
      ce_i && deg > cfg_i.start |=> cs_reg.above && cs_reg.run;
   endproperty
   a_start: assert property (p_start) else $error("fan not run above start");
   property p_crit_off;
      ce_i && cfg_i.crit == ftt_pkg::CRIT_OFF |=> !cs_reg.crit;
   endproperty
   a_crit_off: assert property (p_crit_off) else $error("disabled limit tripped");
   property p_crit_hold;
      ce_i && cs_reg.crit && crit_en && !crit_clr |=> cs_reg.crit;
   endproperty
   a_crit_hold: assert property (p_crit_hold) else $error("override released early");
   property p_crit_rel;
      ce_i && cs_reg.crit && crit_clr && !(deg > cfg_i.crit) |=> !cs_reg.crit;
   endproperty
   a_crit_rel: assert property (p_crit_rel) else $error("override not released");
   property p_min_hold;
      ce_i && cs_reg.fan_on && !off_pt |=> cs_reg.run;
   endproperty
   a_min_hold: assert property (p_min_hold) else $error("fan stopped inside band");
   property p_hold_sel;
      ce_i && cfg_i.hold |=> cs_reg.run;
   endproperty
   a_hold_sel: assert property (p_hold_sel) else $error("hold select ignored");
   property p_ofs;
      cfg_i.ofs == 8'h00 |-> corr == temp_i;
   endproperty
   a_ofs: assert property (p_ofs) else $error("zero offset changed reading");
endmodule // ftt_chan
`default_nettype wire

// >>> hw/ftt_pkg.sv
// package: offsets, reset values, fields and carrier types
package ftt_pkg;
   localparam int NUM_CH = 3;
   localparam int TEMP_W = 10;
   localparam int FRAC_W = 2;
   localparam logic [7:0] ADDR_START0  = 8'h67;
   localparam logic [7:0] ADDR_START1  = 8'h68;
   localparam logic [7:0] ADDR_START2  = 8'h69;
   localparam logic [7:0] ADDR_CRIT0   = 8'h6a;
   localparam logic [7:0] ADDR_CRIT1   = 8'h6b;
   localparam logic [7:0] ADDR_CRIT2   = 8'h6c;
   localparam logic [7:0] ADDR_HYST01  = 8'h6d;
   localparam logic [7:0] ADDR_HYST2   = 8'h6e;
   localparam logic [7:0] ADDR_XTEST   = 8'h6f;
   localparam logic [7:0] ADDR_OFS0    = 8'h70;
   localparam logic [7:0] ADDR_OFS1    = 8'h71;
   localparam logic [7:0] ADDR_CTRL    = 8'h7a;
   localparam logic [7:0] ADDR_STATUS  = 8'h7b;
   localparam logic [7:0] RST_START    = 8'h5a;
   localparam logic [7:0] RST_CRIT     = 8'h64;
   localparam logic [7:0] RST_HYST01   = 8'h44;
   localparam logic [7:0] RST_HYST2    = 8'h40;
   localparam logic [7:0] RST_XTEST    = 8'h00;
   localparam logic [7:0] RST_OFS      = 8'h00;
   localparam logic [7:0] CRIT_OFF     = 8'h80;
   localparam int XTEST_EN_BIT = 0;
   localparam int CTRL_LOCK    = 0;
   localparam int CTRL_PIN_EN  = 1;
   localparam int CTRL_HOLD_LO = 2;
   localparam int HYST_HI_LO   = 4;
   localparam int HYST_W       = 4;
   localparam int ST_FULL      = 0;
   localparam int ST_CRIT_LO   = 1;
   localparam int ST_RUN_LO    = 4;
   localparam int ST_PIN       = 7;

   typedef struct packed {
      logic [7:0]        start;
      logic [7:0]        crit;
      logic [7:0]        ofs;
      logic [HYST_W-1:0] hyst;
      logic              hold;
   } ftt_chan_cfg_t;

   typedef struct packed {
      logic              above;
      logic              run;
      logic              crit;
      logic              trip;
   } ftt_chan_st_t;
endpackage

// >>> hw/ftt_regs.sv
// fan threshold register bank with override and overtemp pin logic
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ftt_regs (
   input  wire logic                               clk_i,
   input  wire logic                               rst_b_i,
   input  wire logic                               ce_i,
   input  wire logic [7:0]                         addr_i,
   input  wire logic [7:0]                         wdata_i,
   input  wire logic                               wr_i,
   input  wire logic                               rd_i,
   output logic      [7:0]                         rdata_o,
   input  wire logic [ftt_pkg::NUM_CH-1:0][ftt_pkg::TEMP_W-1:0] temp_i,
   output logic      [ftt_pkg::NUM_CH-1:0]         fan_ramp_o,
   output logic      [ftt_pkg::NUM_CH-1:0]         fan_min_o,
   output logic                                    full_duty_o,
   output logic                                    xor_tree_enable_o,
   input  wire logic                               overtemp_pin_i,
   output logic                                    overtemp_pin_o,
   output logic                                    overtemp_pin_oe_b_o
);
   localparam int N = ftt_pkg::NUM_CH;

   typedef struct packed {
      logic [N-1:0][7:0] start;
      logic [N-1:0][7:0] crit;
      logic [7:0]        hyst01;
      logic [7:0]        hyst2;
      logic              xtest;
      logic [1:0][7:0]   ofs;
      logic              lock;
      logic              pin_en;
      logic [N-1:0]      hold;
      logic [7:0]        rdata;
      logic [1:0]        pin_sync;
      logic              full;
      logic              pin_drive;
   } ftt_state_t;

   ftt_state_t               st_reg;
   ftt_state_t               st_next;
   ftt_pkg::ftt_chan_cfg_t [N-1:0] cfg;
   ftt_pkg::ftt_chan_st_t  [N-1:0] chs;
   logic [N-1:0]             crit_v;
   logic [N-1:0]             trip_v;
   logic [N-1:0]             run_v;
   logic                     wr_ok;
   logic [7:0]               rd_val;
   logic [N-1:0][7:0]        ofs_ext;

   // remote2 has no offset register
   always_comb begin
      ofs_ext      = '0;
      ofs_ext[1:0] = st_reg.ofs;
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         always_comb begin
            cfg[g].start = st_reg.start[g];
            cfg[g].crit  = st_reg.crit[g];
            cfg[g].ofs   = ofs_ext[g];
            cfg[g].hold  = st_reg.hold[g];
            if (g == 0) begin
               cfg[g].hyst = st_reg.hyst01[7:ftt_pkg::HYST_HI_LO];
            end else if (g == 1) begin
               cfg[g].hyst = st_reg.hyst01[ftt_pkg::HYST_W-1:0];
            end else begin
               cfg[g].hyst = st_reg.hyst2[7:ftt_pkg::HYST_HI_LO];
            end
         end
         ftt_chan u_chan (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .ce_i    (ce_i),
            .temp_i  (temp_i[g]),
            .cfg_i   (cfg[g]),
            .st_o    (chs[g])
         );
         assign crit_v[g]     = chs[g].crit;
         assign trip_v[g]     = chs[g].trip;
         assign run_v[g]      = chs[g].run;
         assign fan_ramp_o[g] = chs[g].above;
      end
   endgenerate

   // register read mux
   always_comb begin
      case (addr_i)
         ftt_pkg::ADDR_START0: rd_val = st_reg.start[0];
         ftt_pkg::ADDR_START1: rd_val = st_reg.start[1];
         ftt_pkg::ADDR_START2: rd_val = st_reg.start[2];
         ftt_pkg::ADDR_CRIT0:  rd_val = st_reg.crit[0];
         ftt_pkg::ADDR_CRIT1:  rd_val = st_reg.crit[1];
         ftt_pkg::ADDR_CRIT2:  rd_val = st_reg.crit[2];
         ftt_pkg::ADDR_HYST01: rd_val = st_reg.hyst01;
         ftt_pkg::ADDR_HYST2:  rd_val = st_reg.hyst2;
         ftt_pkg::ADDR_XTEST:  rd_val = {7'h00, st_reg.xtest};
         ftt_pkg::ADDR_OFS0:   rd_val = st_reg.ofs[0];
         ftt_pkg::ADDR_OFS1:   rd_val = st_reg.ofs[1];
         ftt_pkg::ADDR_CTRL:   rd_val = {3'h0, st_reg.hold, st_reg.pin_en, st_reg.lock};
         ftt_pkg::ADDR_STATUS: rd_val = {st_reg.pin_sync[1], run_v, crit_v, st_reg.full};
         default:              rd_val = 8'h00;
      endcase
   end

   // bank writes, lock, sync and outputs
   always_comb begin
      st_next = st_reg;
      wr_ok   = wr_i && !st_reg.lock;
      if (ce_i) begin
         st_next.rdata    = rd_i ? rd_val : 8'h00;
         st_next.pin_sync = {st_reg.pin_sync[0], overtemp_pin_i};
         st_next.full     = |crit_v;
         st_next.pin_drive = st_reg.pin_en && (|trip_v);
         if (wr_ok) begin
            case (addr_i)
               ftt_pkg::ADDR_START0: st_next.start[0] = wdata_i;
               ftt_pkg::ADDR_START1: st_next.start[1] = wdata_i;
               ftt_pkg::ADDR_START2: st_next.start[2] = wdata_i;
               ftt_pkg::ADDR_CRIT0:  st_next.crit[0]  = wdata_i;
               ftt_pkg::ADDR_CRIT1:  st_next.crit[1]  = wdata_i;
               ftt_pkg::ADDR_CRIT2:  st_next.crit[2]  = wdata_i;
               ftt_pkg::ADDR_HYST01: st_next.hyst01   = wdata_i;
               ftt_pkg::ADDR_HYST2:  st_next.hyst2    = wdata_i;
               ftt_pkg::ADDR_XTEST:  st_next.xtest    = wdata_i[ftt_pkg::XTEST_EN_BIT];
               ftt_pkg::ADDR_OFS0:   st_next.ofs[0]   = wdata_i;
               ftt_pkg::ADDR_OFS1:   st_next.ofs[1]   = wdata_i;
               default: begin
               end
            endcase
         end
         if (wr_i && addr_i == ftt_pkg::ADDR_CTRL) begin
            st_next.lock   = st_reg.lock | wdata_i[ftt_pkg::CTRL_LOCK];
            st_next.pin_en = wdata_i[ftt_pkg::CTRL_PIN_EN];
            st_next.hold   = wdata_i[ftt_pkg::CTRL_HOLD_LO +: N];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg.start    <= {N{ftt_pkg::RST_START}};
         st_reg.crit     <= {N{ftt_pkg::RST_CRIT}};
         st_reg.hyst01   <= ftt_pkg::RST_HYST01;
         st_reg.hyst2    <= ftt_pkg::RST_HYST2;
         st_reg.xtest    <= ftt_pkg::RST_XTEST[ftt_pkg::XTEST_EN_BIT];
         st_reg.ofs      <= {2{ftt_pkg::RST_OFS}};
         st_reg.lock     <= 1'b0;
         st_reg.pin_en   <= 1'b0;
         st_reg.hold     <= '0;
         st_reg.rdata    <= 8'h00;
         st_reg.pin_sync <= 2'h3;
         st_reg.full     <= 1'b0;
         st_reg.pin_drive <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      rdata_o             = st_reg.rdata;
      fan_min_o           = run_v;
      full_duty_o         = st_reg.full;
      xor_tree_enable_o   = st_reg.xtest;
      overtemp_pin_o      = 1'b0;
      overtemp_pin_oe_b_o = !st_reg.pin_drive;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_lock;
      ce_i && st_reg.lock && wr_i && addr_i != ftt_pkg::ADDR_CTRL
      |=> $stable({st_reg.start, st_reg.crit, st_reg.hyst01, st_reg.hyst2,
                   st_reg.xtest, st_reg.ofs});
   endproperty
   a_lock: assert property (p_lock) else $error("locked register changed");
   property p_lock_sticky;
      st_reg.lock |=> st_reg.lock;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
   property p_full;
      ce_i && (|crit_v) |=> full_duty_o ##0 $past(crit_v) != '0;
   endproperty
   a_full: assert property (p_full) else $error("no full duty on override");
   property p_full_off;
      ce_i && crit_v == '0 |=> !full_duty_o;
   endproperty
   a_full_off: assert property (p_full_off) else $error("full duty without cause");
   property p_pin;
      ce_i && st_reg.pin_en && (|trip_v) |=> !overtemp_pin_oe_b_o;
   endproperty
   a_pin: assert property (p_pin) else $error("overtemp pin not driven");
   property p_pin_off;
      ce_i && !st_reg.pin_en |=> overtemp_pin_oe_b_o;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");
   property p_hyst;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_HYST01
      |=> cfg[0].hyst == $past(wdata_i[7:4]) && cfg[1].hyst == $past(wdata_i[3:0]);
   endproperty
   a_hyst: assert property (p_hyst) else $error("hysteresis nibble wrong");
   property p_xor;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_XTEST
      |=> xor_tree_enable_o == $past(wdata_i[0]) ##1
          ($past(wr_i) || xor_tree_enable_o == $past(wdata_i[0], 2));
   endproperty
   a_xor: assert property (p_xor) else $error("xor test enable wrong");
   property p_rd;
      ce_i && rd_i |=> rdata_o == $past(rd_val);
   endproperty
   a_rd: assert property (p_rd) else $error("read data wrong");
   property p_rd_idle;
      ce_i && !rd_i |=> rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
   property p_freeze;
      !ce_i |=> $stable(st_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while disabled");
   property p_wr_start0;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_START0
      |=> cfg[0].start == $past(wdata_i);
   endproperty
   a_wr_start0: assert property (p_wr_start0) else $error("start write lost");
   property p_wr_start2;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_START2
      |=> cfg[2].start == $past(wdata_i);
   endproperty
   a_wr_start2: assert property (p_wr_start2) else $error("start write lost");
   property p_wr_crit0;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_CRIT0
      |=> cfg[0].crit == $past(wdata_i);
   endproperty
   a_wr_crit0: assert property (p_wr_crit0) else $error("limit write lost");
   property p_wr_crit2;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_CRIT2
      |=> cfg[2].crit == $past(wdata_i);
   endproperty
   a_wr_crit2: assert property (p_wr_crit2) else $error("limit write lost");
   property p_wr_hyst2;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_HYST2
      |=> cfg[2].hyst == $past(wdata_i[7:4]);
   endproperty
   a_wr_hyst2: assert property (p_wr_hyst2) else $error("remote2 hysteresis wrong");
   property p_wr_ofs0;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_OFS0
      |=> cfg[0].ofs == $past(wdata_i);
   endproperty
   a_wr_ofs0: assert property (p_wr_ofs0) else $error("offset write lost");
   property p_wr_ofs1;
      ce_i && !st_reg.lock && wr_i && addr_i == ftt_pkg::ADDR_OFS1
      |=> cfg[1].ofs == $past(wdata_i);
   endproperty
   a_wr_ofs1: assert property (p_wr_ofs1) else $error("offset write lost");
   property p_xor_rsvd;
      ce_i && rd_i && addr_i == ftt_pkg::ADDR_XTEST |=> rdata_o[7:1] == 7'h00;
   endproperty
   a_xor_rsvd: assert property (p_xor_rsvd) else $error("reserved test bits set");
   property p_pin_en;
      ce_i && wr_i && addr_i == ftt_pkg::ADDR_CTRL
      |=> st_reg.pin_en == $past(wdata_i[ftt_pkg::CTRL_PIN_EN]);
   endproperty
   a_pin_en: assert property (p_pin_en) else $error("pin enable write lost");
   property p_lock_set;
      ce_i && wr_i && addr_i == ftt_pkg::ADDR_CTRL && wdata_i[ftt_pkg::CTRL_LOCK]
      |=> st_reg.lock;
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock bit not set");
   property p_hold_ctrl;
      ce_i && wr_i && addr_i == ftt_pkg::ADDR_CTRL
      |=> st_reg.hold == $past(wdata_i[ftt_pkg::CTRL_HOLD_LO +: N]);
   endproperty
   a_hold_ctrl: assert property (p_hold_ctrl) else $error("hold select write lost");
   property p_full_hold;
      ce_i && full_duty_o && crit_v != '0 |=> full_duty_o;
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("full duty dropped early");
   property p_pin_sync;
      ce_i |=> st_reg.pin_sync[0] == $past(overtemp_pin_i);
   endproperty
   a_pin_sync: assert property (p_pin_sync) else $error("pin sampler wrong");
   property p_status;
      ce_i && rd_i && addr_i == ftt_pkg::ADDR_STATUS |=> rdata_o[0] == $past(full_duty_o);
   endproperty
   a_status: assert property (p_status) else $error("status full bit wrong");
   property p_pin_rel;
      ce_i && trip_v == '0 |=> overtemp_pin_oe_b_o;
   endproperty
   a_pin_rel: assert property (p_pin_rel) else $error("pin held without trip");
   property p_xtest_lock;
      ce_i && st_reg.lock |=> $stable(xor_tree_enable_o);
   endproperty
   a_xtest_lock: assert property (p_xtest_lock) else $error("locked test bit moved");
endmodule // ftt_regs
`default_nettype wire

// >>> sim/tb_ftt_regs.sv
// self-checking bench for the fan threshold register bank
`timescale 1ns/1ps
`default_nettype none
module tb_ftt_regs;
   logic       clk_i;
   logic       rst_b_i;
   logic       ce_i;
   logic [7:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic [ftt_pkg::NUM_CH-1:0][ftt_pkg::TEMP_W-1:0] temp_i;
   logic [2:0] fan_ramp_o;
   logic [2:0] fan_min_o;
   logic       full_duty_o;
   logic       xor_tree_enable_o;
   logic       overtemp_pin_o;
   logic       overtemp_pin_oe_b_o;
   wire        pin_level;
   int         miscompares;
   int         comparisons;
   int         cycles;
   logic [7:0] reg_val [11];

   // pulled up unless the block drives it
   assign pin_level = overtemp_pin_oe_b_o ? 1'b1 : overtemp_pin_o;

   ftt_regs DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .temp_i(temp_i),
      .fan_ramp_o(fan_ramp_o), .fan_min_o(fan_min_o), .full_duty_o(full_duty_o),
      .xor_tree_enable_o(xor_tree_enable_o), .overtemp_pin_i(pin_level),
      .overtemp_pin_o(overtemp_pin_o), .overtemp_pin_oe_b_o(overtemp_pin_oe_b_o));

   always #5 clk_i = ~clk_i;

   task automatic give_verdict();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp, "read");
   endtask

   // set one channel, let flags settle, then compare the fan, full duty and pin outputs
   task automatic tmp(input int ch, input logic [9:0] raw, input logic [2:0] ramp,
                      input logic [2:0] fmin, input logic full, input logic oe_b);
      @(posedge clk_i);
      temp_i[ch] <= raw;
      repeat (3) @(posedge clk_i);
      #1;
      chk({5'h0, fan_ramp_o}, {5'h0, ramp}, "ramp");
      chk({5'h0, fan_min_o}, {5'h0, fmin}, "fan min");
      chk({7'h0, full_duty_o}, {7'h0, full}, "full duty");
      chk({7'h0, overtemp_pin_oe_b_o}, {7'h0, oe_b}, "pin enable");
      chk({7'h0, pin_level}, {7'h0, oe_b}, "pin level");
   endtask

   task automatic t_reset();
      #1;
      chk({fan_ramp_o, fan_min_o, full_duty_o, overtemp_pin_oe_b_o}, 8'h01, "reset out");
      chk({7'h0, xor_tree_enable_o}, 8'h00, "reset xor");
      for (int i = 0; i < 11; i++) begin
         rd_chk(8'h67 + 8'(i), reg_val[i]);
      end
      wr_reg(8'h50, 8'hff);
      rd_chk(8'h50, 8'h00);
   endtask

   task automatic t_rw();
      for (int i = 0; i < 11; i++) begin
         wr_reg(8'h67 + 8'(i), (i == 8) ? 8'h01 : 8'h50 + 8'(i));
      end
      for (int i = 0; i < 11; i++) begin
         rd_chk(8'h67 + 8'(i), (i == 8) ? 8'h01 : 8'h50 + 8'(i));
      end
      chk({7'h0, xor_tree_enable_o}, 8'h01, "xor on");
      for (int i = 0; i < 11; i++) begin
         wr_reg(8'h67 + 8'(i), reg_val[i]);
      end
      #1;
      chk({7'h0, xor_tree_enable_o}, 8'h00, "xor off");
   endtask

   task automatic t_start();
      tmp(0, 10'd364, 3'b001, 3'b001, 1'b0, 1'b1);
      tmp(0, 10'd352, 3'b000, 3'b001, 1'b0, 1'b1);
      tmp(0, 10'd344, 3'b000, 3'b000, 1'b0, 1'b1);
      tmp(0, 10'd348, 3'b000, 3'b000, 1'b0, 1'b1);
      wr_reg(ftt_pkg::ADDR_CTRL, 8'h04);
      rd_chk(ftt_pkg::ADDR_CTRL, 8'h04);
      tmp(0, 10'd348, 3'b000, 3'b001, 1'b0, 1'b1);
      wr_reg(ftt_pkg::ADDR_CTRL, 8'h00);
      tmp(0, 10'd80, 3'b000, 3'b000, 1'b0, 1'b1);
      wr_reg(8'h6d, 8'h4a);
      tmp(1, 10'd364, 3'b010, 3'b010, 1'b0, 1'b1);
      tmp(1, 10'd324, 3'b000, 3'b010, 1'b0, 1'b1);
      tmp(1, 10'd320, 3'b000, 3'b000, 1'b0, 1'b1);
      wr_reg(8'h6d, 8'h44);
      tmp(1, 10'd80, 3'b000, 3'b000, 1'b0, 1'b1);
   endtask

   task automatic t_crit();
      wr_reg(ftt_pkg::ADDR_CTRL, 8'h02);
      tmp(0, 10'd400, 3'b001, 3'b001, 1'b0, 1'b1);
      tmp(0, 10'd401, 3'b001, 3'b001, 1'b0, 1'b0);
      tmp(0, 10'd404, 3'b001, 3'b001, 1'b1, 1'b0);
      rd_chk(ftt_pkg::ADDR_STATUS, 8'h13);
      wr_reg(ftt_pkg::ADDR_CTRL, 8'h00);
      tmp(0, 10'd388, 3'b001, 3'b001, 1'b1, 1'b1);
      tmp(0, 10'd384, 3'b001, 3'b001, 1'b1, 1'b1);
      tmp(0, 10'd380, 3'b001, 3'b001, 1'b0, 1'b1);
      tmp(0, 10'd80, 3'b000, 3'b000, 1'b0, 1'b1);
      tmp(2, 10'd404, 3'b100, 3'b100, 1'b1, 1'b1);
      tmp(2, 10'd80, 3'b000, 3'b000, 1'b0, 1'b1);
   endtask

   task automatic t_disable();
      wr_reg(ftt_pkg::ADDR_CTRL, 8'h02);
      wr_reg(8'h6b, 8'h80);
      tmp(1, 10'd800, 3'b010, 3'b010, 1'b0, 1'b1);
      wr_reg(8'h6b, 8'h64);
      tmp(1, 10'd800, 3'b010, 3'b010, 1'b1, 1'b0);
      wr_reg(ftt_pkg::ADDR_CTRL, 8'h00);
      tmp(1, 10'd80, 3'b000, 3'b000, 1'b0, 1'b1);
   endtask

   task automatic t_offset();
      wr_reg(8'h70, 8'hfc);
      tmp(0, 10'd404, 3'b001, 3'b001, 1'b0, 1'b1);
      wr_reg(8'h70, 8'h04);
      tmp(0, 10'd400, 3'b001, 3'b001, 1'b1, 1'b1);
      wr_reg(8'h70, 8'h00);
      tmp(0, 10'd80, 3'b000, 3'b000, 1'b0, 1'b1);
   endtask

   // clock enable low: writes and channel flags stay frozen
   task automatic t_freeze();
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr_reg(ftt_pkg::ADDR_START0, 8'h10);
      tmp(0, 10'd404, 3'b000, 3'b000, 1'b0, 1'b1);
      @(posedge clk_i);
      ce_i <= 1'b1;
      rd_chk(ftt_pkg::ADDR_START0, 8'h5a);
      tmp(0, 10'd404, 3'b001, 3'b001, 1'b1, 1'b1);
      tmp(0, 10'd80, 3'b000, 3'b000, 1'b0, 1'b1);
   endtask

   task automatic t_lock();
      wr_reg(ftt_pkg::ADDR_CTRL, 8'h01);
      for (int i = 0; i < 11; i++) begin
         wr_reg(8'h67 + 8'(i), (i == 8) ? 8'h01 : ~reg_val[i]);
      end
      for (int i = 0; i < 11; i++) begin
         rd_chk(8'h67 + 8'(i), reg_val[i]);
      end
      chk({7'h0, xor_tree_enable_o}, 8'h00, "xor locked");
   endtask

   initial begin
      clk_i = 1'b0;
      rst_b_i = 1'b0;
      ce_i = 1'b1;
      addr_i = 8'h00;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      temp_i = {3{10'd80}};
      reg_val = '{8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00,
                  8'h00, 8'h00};
      repeat (6) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_rw();
      t_start();
      t_crit();
      t_disable();
      t_offset();
      t_freeze();
      t_lock();
      give_verdict();
   end
endmodule // tb_ftt_regs
`default_nettype wire
